//--- csr_map.svh
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// ----------------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------------
`define CSR_IDX_OSC        8'hd3
`define CSR_IDX_CLK        8'hd4
`define CSR_IDX_BT         8'hdc
`define CSR_IDX_KEY        8'he0
`define CSR_IDX_STAT       8'hf8
`define CSR_ADDR_W         12

// ----------------------------------------------------------------------
// Field positions and values.
// ----------------------------------------------------------------------
`define CSR_OSC_SEL        0
`define CSR_OSC_SUB_STOP   2
`define CSR_OSC_MAIN_STOP  3
`define CSR_OSC_MASK       8'h0d
`define CSR_CLK_DIV_LO     3
`define CSR_CLK_WAKE_DIS   7
`define CSR_BT_STAB_LO     2
`define CSR_BT_WD_KEY      4'ha
`define CSR_STOP_KEY       8'ha5

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define CSR_OSC_RST        8'h00
`define CSR_CLK_RST        8'h00
`define CSR_BT_RST         8'h00
`define CSR_KEY_RST        8'h00
`define CSR_RESET_VEC      16'h0100

// ----------------------------------------------------------------------
// Timing: clock rate and oscillation stabilisation interval.
// ----------------------------------------------------------------------
`define CSR_CLK_MHZ        200
`define CSR_STAB_US        1000
`define CSR_STAB_CYC       (`CSR_STAB_US * `CSR_CLK_MHZ)
`define CSR_STAB_W         24
`define CSR_SYNC_W         3

`endif

//--- csr_pkg.sv
`include "csr_map.svh"

package csr_pkg;

   // ----------------------------------------------------------------------
   // Sequencer states and carriers.
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_RESET, ST_STAB, ST_RUN, ST_STOP} csr_state_t;

   typedef logic [`CSR_STAB_W-1:0] csr_stab_t;

   typedef struct packed {
      logic                   psel;
      logic                   penable;
      logic                   pwrite;
      logic [`CSR_ADDR_W-1:0] paddr;
      logic [31:0]            pwdata;
   } csr_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } csr_apb_rsp_t;

   typedef struct packed {
      logic sys_clk_sel;
      logic main_osc_en;
      logic sub_osc_en;
      logic cpu_tick;
   } csr_clk_out_t;

   typedef struct packed {
      logic        sys_reset;
      logic        port_reset_mode;
      logic        irq_disable;
      logic        watchdog_en;
      logic        cpu_halt;
      logic        stop_mode;
      logic        fetch_en;
      logic        pc_load;
      logic [15:0] pc_vector;
      logic        irq_service;
      logic        stop_ignored;
   } csr_sys_out_t;

   typedef struct packed {
      csr_state_t   st;
      logic [7:0]   osc;
      logic [7:0]   clk;
      logic [7:0]   bt;
      logic [7:0]   key;
      logic [3:0]   div_cnt;
      csr_stab_t    stab_cnt;
      logic         wake_irq;
      csr_apb_rsp_t rsp;
      csr_clk_out_t clk_o;
      csr_sys_out_t sys_o;
   } csr_regs_t;

   typedef struct packed {
      logic [`CSR_SYNC_W-1:0] s1;
      logic [`CSR_SYNC_W-1:0] s2;
   } csr_sync_t;

endpackage

//--- csr_sync.sv
`include "csr_map.svh"

module csr_sync (
   // Clock and reset.
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [`CSR_SYNC_W-1:0] din,
   output      logic [`CSR_SYNC_W-1:0] dout
);
   import csr_pkg::*;

   csr_sync_t q;
   csr_sync_t next_q;

   // The first stage feeds only the second stage.
   always_comb begin
      next_q    = q;
      next_q.s1 = din;
      next_q.s2 = q.s1;
   end

   // Both stages clear to zero under reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign dout = q.s2;

endmodule

//--- csr_ctrl.sv
`include "csr_map.svh"

// Summary of operation
// [R1] Oscillator control bit 0 picks system clock: 0 main, 1 sub.
// [R2] Oscillator control bit 3: 0 runs main oscillator, 1 stops it.
// [R3] Oscillator control bit 2 runs or stops the sub oscillator.
// [R4] Divider bits 4:3 divide the system clock by 16, 8, 2 or 1.
// [R5] Firmware selects sub clock, waits, then stops the main oscillator.
// [R6] Firmware starts main oscillator, waits to settle, then selects main.
// [R7] Stop is permitted only while the key register holds a5.
// [R8] After reset the key register holds zero, so stop is disabled.
// [R9] The reset pin is synchronised to the clock before use.
// [R10] The reset driver holds reset low at least one millisecond; the CPU model holds rst_pin_n low only RST_HOLD (6) pclk cycles.
// [R11] Reset disables all interrupts and enables the watchdog.
// [R12] Reset puts ports in Schmitt input mode with pull-ups off.
// [R13] Reset loads vector 0100 and fetches after stabilisation time.
// [R14] Timer overflow resets the system unless upper timer nibble is a.
// [R15] Stop halts the CPU and main oscillator; sub clock keeps running.
// [R16] Register contents are kept throughout stop mode.
// [R17] Stop ends on reset, sub-clocked watch timer interrupt or external interrupt; ext_irq wakes only while clock control bit 7 is 0.
// [R18] Firmware follows stop with at least three no-operation instructions.
// [R19] Reset out of stop restores control defaults, restarts at 0100.
// [R20] Interrupt release of stop leaves every control register unchanged.
// [R21] Interrupt release of stop keeps the selected clock division.
// [R22] Interrupt release services the interrupt, then resumes after stop.
// [R23] With sub clock as system clock no interrupt releases stop.
// [R24] Stop without the key does nothing; the CPU carries on.
module csr_ctrl #(
   parameter csr_pkg::csr_stab_t STAB_CYC = csr_pkg::csr_stab_t'(`CSR_STAB_CYC)
) (
   // Clock and reset.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // Register bus.
   input  wire csr_pkg::csr_apb_req_t apb_req,
   output      csr_pkg::csr_apb_rsp_t apb_rsp,
   // Pins, asynchronous to pclk.
   input  wire logic                  rst_pin_n,
   input  wire logic                  ext_irq,
   input  wire logic                  wt_irq,
   // CPU and peripheral side, on pclk.
   input  wire logic                  stop_req,
   input  wire logic                  ei_req,
   input  wire logic                  bt_overflow,
   input  wire logic                  wt_on_sub,
   // Clock and system controls.
   output      csr_pkg::csr_clk_out_t clk_out,
   output      csr_pkg::csr_sys_out_t sys_out
);
   import csr_pkg::*;

   // ----------------------------------------------------------------------
   // State and working signals.
   // ----------------------------------------------------------------------
   csr_regs_t              q;
   csr_regs_t              next_q;
   logic [`CSR_SYNC_W-1:0] sync_out;
   logic                   rst_s;
   logic                   ext_s;
   logic                   wt_s;
   logic [9:0]             idx;
   logic                   hit;
   logic                   setup;
   logic                   wr;
   logic [7:0]             rdata;
   logic                   wake;
   logic                   wd_trip;
   logic [3:0]             div_max;
   csr_stab_t              stab_lim;

   // Reset pin and interrupt pins pass two flip-flops first.
   csr_sync u_sync ( // see [R9]
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({wt_irq, ext_irq, rst_pin_n}),
      .dout    (sync_out)
   );

   assign rst_s = sync_out[0];
   assign ext_s = sync_out[1];
   assign wt_s  = sync_out[2];

   // ----------------------------------------------------------------------
   // Bus decode and read data.
   // ----------------------------------------------------------------------

   // Address decode over word indexes; reads are sampled in the setup cycle.
   always_comb begin
      idx   = apb_req.paddr[`CSR_ADDR_W-1:2];
      setup = apb_req.psel & ~apb_req.penable;
      wr    = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite;
      hit   = 1'b1;
      rdata = 8'h00;
      unique case (idx)
         {2'b00, `CSR_IDX_OSC}:  rdata = q.osc & `CSR_OSC_MASK;
         {2'b00, `CSR_IDX_CLK}:  rdata = q.clk;
         {2'b00, `CSR_IDX_BT}:   rdata = q.bt;
         {2'b00, `CSR_IDX_KEY}:  rdata = q.key;
         {2'b00, `CSR_IDX_STAT}: rdata = {5'h00, q.wake_irq, q.st};
         default:                hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Wake, watchdog, divider and stabilisation terms.
   // ----------------------------------------------------------------------

   // Wake sources are blocked while the sub clock is the system clock.
   always_comb begin
      wake = ((ext_s & ~q.clk[`CSR_CLK_WAKE_DIS]) | (wt_s & wt_on_sub)) // see [R17]
             & ~q.osc[`CSR_OSC_SEL]; // see [R23]
      wd_trip  = bt_overflow & (q.bt[7:4] != `CSR_BT_WD_KEY); // see [R14]
      stab_lim = STAB_CYC << q.bt[`CSR_BT_STAB_LO +: 2];
      unique case (q.clk[`CSR_CLK_DIV_LO +: 2]) // see [R4]
         2'b00: div_max = 4'hf;
         2'b01: div_max = 4'h7;
         2'b10: div_max = 4'h1;
         2'b11: div_max = 4'h0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Next state.
   // ----------------------------------------------------------------------

   // Bus slave, register writes, sequencer and registered outputs.
   always_comb begin
      next_q                    = q;
      next_q.rsp.pready         = setup;
      next_q.sys_o.pc_load      = 1'b0;
      next_q.sys_o.irq_service  = 1'b0;
      next_q.sys_o.stop_ignored = 1'b0;
      next_q.clk_o.cpu_tick     = 1'b0;
      if (setup) begin
         next_q.rsp.prdata  = {24'h000000, rdata};
         next_q.rsp.pslverr = ~hit;
      end

      // Writes land only at the completing edge of the access phase.
      if (wr) begin
         unique case (idx)
            {2'b00, `CSR_IDX_OSC}: next_q.osc = apb_req.pwdata[7:0] & `CSR_OSC_MASK;
            {2'b00, `CSR_IDX_CLK}: next_q.clk = apb_req.pwdata[7:0];
            {2'b00, `CSR_IDX_BT}:  next_q.bt  = apb_req.pwdata[7:0];
            {2'b00, `CSR_IDX_KEY}: next_q.key = apb_req.pwdata[7:0];
            default: ;
         endcase
      end

      unique case (q.st)
         ST_RESET: begin
            next_q.stab_cnt = '0;
            next_q.wake_irq = 1'b0;
            if (rst_s) begin
               next_q.st = ST_STAB;
            end
         end
         ST_STAB: begin
            // Count out the stabilisation interval before any fetch.
            if (q.stab_cnt >= stab_lim - 1'b1) begin // see [R13]
               next_q.st       = ST_RUN;
               next_q.stab_cnt = '0;
               if (q.wake_irq) begin
                  next_q.sys_o.irq_service = 1'b1; // see [R22]
               end else begin
                  next_q.sys_o.pc_load = 1'b1; // see [R13]
               end
            end else begin
               next_q.stab_cnt = q.stab_cnt + 1'b1;
            end
         end
         ST_RUN: begin
            if (stop_req) begin
               if (q.key == `CSR_STOP_KEY) begin // see [R7]
                  next_q.st = ST_STOP;
               end else begin
                  next_q.sys_o.stop_ignored = 1'b1; // see [R24]
               end
            end
         end
         ST_STOP: begin
            // Registers stay as they are; on wake the state moves on and wake_irq is set.
            if (wake) begin // see [R16] [R20] [R21]
               next_q.st       = ST_STAB;
               next_q.wake_irq = 1'b1;
               next_q.stab_cnt = '0;
            end
         end
      endcase

      // Pin reset or watchdog trip restores every control default.
      if (!rst_s || wd_trip) begin // see [R19] [R14]
         next_q.st       = ST_RESET;
         next_q.osc      = `CSR_OSC_RST;
         next_q.clk      = `CSR_CLK_RST;
         next_q.bt       = `CSR_BT_RST;
         next_q.key      = `CSR_KEY_RST; // see [R8]
         next_q.wake_irq = 1'b0;
         next_q.stab_cnt = '0;
         // A reset in the last cycle of a start must not also start the CPU.
         next_q.sys_o.pc_load      = 1'b0;
         next_q.sys_o.irq_service  = 1'b0;
         next_q.sys_o.stop_ignored = 1'b0;
      end

      // CPU clock divider ticks only while the CPU runs.
      if (next_q.st == ST_RUN) begin
         if (q.div_cnt == 4'h0) begin
            next_q.div_cnt        = div_max; // see [R4]
            next_q.clk_o.cpu_tick = 1'b1;
         end else begin
            next_q.div_cnt = q.div_cnt - 1'b1;
         end
      end else begin
         next_q.div_cnt = 4'h0;
      end

      // Clock source and oscillator controls.
      next_q.clk_o.sys_clk_sel = next_q.osc[`CSR_OSC_SEL]; // see [R1]
      next_q.clk_o.main_osc_en = ~next_q.osc[`CSR_OSC_MAIN_STOP] // see [R2]
                                 & (next_q.st != ST_STOP); // see [R15]
      next_q.clk_o.sub_osc_en  = ~next_q.osc[`CSR_OSC_SUB_STOP]; // see [R3]

      // System reset, port defaults, interrupt gate and CPU status.
      next_q.sys_o.sys_reset       = (next_q.st == ST_RESET)
                                     | ((next_q.st == ST_STAB) & ~next_q.wake_irq);
      next_q.sys_o.port_reset_mode = next_q.sys_o.sys_reset; // see [R12]
      if (next_q.sys_o.sys_reset) begin
         next_q.sys_o.irq_disable = 1'b1; // see [R11]
      end else if (ei_req) begin
         next_q.sys_o.irq_disable = 1'b0;
      end
      next_q.sys_o.watchdog_en = next_q.bt[7:4] != `CSR_BT_WD_KEY; // see [R11]
      next_q.sys_o.cpu_halt    = next_q.st != ST_RUN; // see [R15]
      next_q.sys_o.stop_mode   = next_q.st == ST_STOP;
      next_q.sys_o.fetch_en    = next_q.st == ST_RUN;
      next_q.sys_o.pc_vector   = `CSR_RESET_VEC;
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------

   // Reset values: held in reset with the CPU halted and interrupts off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q                       <= '0;
         q.st                    <= ST_RESET;
         q.osc                   <= `CSR_OSC_RST;
         q.clk                   <= `CSR_CLK_RST;
         q.bt                    <= `CSR_BT_RST;
         q.key                   <= `CSR_KEY_RST;
         q.clk_o.main_osc_en     <= 1'b1;
         q.clk_o.sub_osc_en      <= 1'b1;
         q.sys_o.sys_reset       <= 1'b1;
         q.sys_o.port_reset_mode <= 1'b1;
         q.sys_o.irq_disable     <= 1'b1;
         q.sys_o.watchdog_en     <= 1'b1;
         q.sys_o.cpu_halt        <= 1'b1;
         q.sys_o.pc_vector       <= `CSR_RESET_VEC;
      end else begin
         q <= next_q;
      end
   end

   assign apb_rsp = q.rsp;
   assign clk_out = q.clk_o;
   assign sys_out = q.sys_o;

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------

   a_clk_sel_write: assert property ( // see [R1]
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == {2'b00, `CSR_IDX_OSC} && rst_s && !wd_trip)
      |=> q.clk_o.sys_clk_sel == $past(apb_req.pwdata[0])
   ) else $error("System clock select does not follow the write.");

   a_main_osc_run: assert property ( // see [R2]
      @(posedge pclk) disable iff (!presetn)
      (q.st == ST_RUN) |-> (q.clk_o.main_osc_en == !q.osc[`CSR_OSC_MAIN_STOP])
   ) else $error("Main oscillator enable disagrees with its control bit.");

   a_sub_osc_run: assert property ( // see [R3]
      @(posedge pclk) disable iff (!presetn)
      q.clk_o.sub_osc_en != q.osc[`CSR_OSC_SUB_STOP]
   ) else $error("Sub oscillator enable disagrees with its control bit.");

   a_div_sixteen: assert property ( // see [R4]
      @(posedge pclk) disable iff (!presetn)
      (q.clk_o.cpu_tick && q.clk[`CSR_CLK_DIV_LO +: 2] == 2'b00)
      |=> (!q.clk_o.cpu_tick) [*8]
   ) else $error("CPU tick came early at divide by sixteen.");

   a_key_refuse: assert property ( // see [R7] [R24]
      @(posedge pclk) disable iff (!presetn)
      (q.st == ST_RUN && stop_req && q.key != `CSR_STOP_KEY && rst_s && !wd_trip)
      |=> (q.st == ST_RUN && q.sys_o.stop_ignored)
   ) else $error("Stop without key was not ignored.");

   a_key_at_reset: assert property ( // see [R8]
      @(posedge pclk) disable iff (!presetn)
      (q.st == ST_RESET) |-> (q.key == `CSR_KEY_RST && q.sys_o.irq_disable)
   ) else $error("Key or interrupt gate not at default during reset.");

   a_wdog_reset: assert property ( // see [R14]
      @(posedge pclk) disable iff (!presetn)
      wd_trip |=> (q.st == ST_RESET && q.sys_o.sys_reset)
   ) else $error("Watchdog overflow did not reset the system.");

   a_stop_halts: assert property ( // see [R15]
      @(posedge pclk) disable iff (!presetn)
      (q.st == ST_STOP) |-> (q.sys_o.cpu_halt && !q.clk_o.main_osc_en && !q.clk_o.cpu_tick)
   ) else $error("Stop mode left the CPU or main oscillator running.");

   a_sub_no_wake: assert property ( // see [R23]
      @(posedge pclk) disable iff (!presetn)
      (q.st == ST_STOP && q.osc[`CSR_OSC_SEL])
      |=> (q.st != ST_STAB)
   ) else $error("Interrupt released stop under sub clock.");

   a_irq_resume: assert property ( // see [R22]
      @(posedge pclk) disable iff (!presetn)
      q.sys_o.irq_service |-> (!q.sys_o.pc_load && q.st == ST_RUN && $past(q.st) == ST_STAB)
   ) else $error("Interrupt release did not resume correctly.");

   a_vector_fetch: assert property ( // see [R13]
      @(posedge pclk) disable iff (!presetn)
      q.sys_o.pc_load |-> (q.sys_o.pc_vector == `CSR_RESET_VEC && $past(q.st) == ST_STAB)
   ) else $error("Reset vector loaded outside stabilisation end.");

   a_reset_gates: assert property ( // see [R11] [R12]
      @(posedge pclk) disable iff (!presetn)
      q.sys_o.sys_reset |-> (q.sys_o.irq_disable && q.sys_o.port_reset_mode)
   ) else $error("System reset left interrupts or ports out of default.");

   a_pin_reset_wins: assert property ( // see [R19]
      @(posedge pclk) disable iff (!presetn)
      !rst_s |=> (q.st == ST_RESET && !q.sys_o.pc_load && !q.sys_o.irq_service)
   ) else $error("Pin reset did not hold the CPU in reset.");

endmodule

//--- csr_cpu_model.sv
`include "csr_map.svh"

module csr_cpu_model #(
   parameter int RST_HOLD = 6
) (
   // Clock and reset.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // Commands from the bench.
   input  wire logic                  do_stop,
   input  wire logic                  do_pin_rst,
   // Block status seen by the core.
   input  wire csr_pkg::csr_sys_out_t sys_out,
   // Requests and pin towards the block.
   output      logic                  stop_req,
   output      logic                  ei_req,
   output      logic                  rst_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import csr_pkg::*;

   int nop_cnt;
   int pin_cnt;

   // The core stops only while fetching, then spends three idle slots; it re-enables
   // interrupts at every start and holds the reset pin low for a fixed span.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_req  <= 1'b0;
         ei_req    <= 1'b0;
         nop_cnt   <= 0;
         pin_cnt   <= 0;
         rst_pin_n <= 1'b1;
      end else begin
         stop_req  <= do_stop && sys_out.fetch_en && nop_cnt == 0;
         nop_cnt   <= stop_req ? 3 : (nop_cnt > 0 ? nop_cnt - 1 : 0);
         ei_req    <= sys_out.pc_load || sys_out.irq_service;
         pin_cnt   <= do_pin_rst ? RST_HOLD : (pin_cnt > 0 ? pin_cnt - 1 : 0);
         rst_pin_n <= !(do_pin_rst || pin_cnt > 1);
      end
   end
endmodule

//--- csr_tb.sv
`include "csr_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAITF(c) begin int k; k = 0; while (!(c) && k < 3000) begin @(posedge pclk); k++; end if (!(c)) begin num_errors++; end_of_test(); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import csr_pkg::*;

   localparam int STAB = 8;
   logic         pclk, presetn, ext_irq, wt_irq, wt_on_sub, bt_overflow;
   logic         do_stop, do_pin_rst, stop_req, ei_req, rst_pin_n;
   logic [15:0]  lfsr;
   csr_apb_req_t req;
   csr_apb_rsp_t rsp;
   csr_clk_out_t co;
   csr_sys_out_t so;
   int           num_errors, check_count, n;
   int           mreg [int];
   int           gaps [4] = '{16, 8, 2, 1};

   csr_ctrl #(.STAB_CYC(csr_stab_t'(STAB))) csr_ctrl_i (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .rst_pin_n(rst_pin_n), .ext_irq(ext_irq), .wt_irq(wt_irq), .stop_req(stop_req),
      .ei_req(ei_req), .bt_overflow(bt_overflow), .wt_on_sub(wt_on_sub), .clk_out(co), .sys_out(so));
   csr_cpu_model csr_cpu_model_i (.pclk(pclk), .presetn(presetn), .do_stop(do_stop), .do_pin_rst(do_pin_rst),
      .sys_out(so), .stop_req(stop_req), .ei_req(ei_req), .rst_pin_n(rst_pin_n));

   // Clock at 200 MHz.
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Cuts a hung run short.
   initial begin
      repeat (100000) @(posedge pclk);
      num_errors++;
      end_of_test();
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One APB transfer, checked against the register model.
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      logic ee;
      ee = !mreg.exists(idx);
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'h0, d}};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         end_of_test();
      end
      `CHK("pslverr", ee, rsp.pslverr)
      if (!w && !ee && idx != `CSR_IDX_STAT) `CHK("prdata", 32'(mreg[idx]), rsp.prdata)
      if (w && !ee && idx != `CSR_IDX_STAT) mreg[idx] = (idx == `CSR_IDX_OSC) ? d & `CSR_OSC_MASK : d;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // Next value of the stimulus shift register.
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // Model of a system reset: every control register returns to zero.
   task automatic mreset();
      foreach (mreg[i]) mreg[i] = 0;
   endtask

   task automatic rd_all();
      foreach (mreg[i]) apb(1'b0, 8'(i), 8'h00);
   endtask

   // Compares the clock controls with the model after the write lands.
   task automatic chk_osc();
      repeat (2) @(posedge pclk);
      `CHK("sys_clk_sel", mreg[`CSR_IDX_OSC][0], co.sys_clk_sel)
      `CHK("main_osc_en", !mreg[`CSR_IDX_OSC][3], co.main_osc_en)
      `CHK("sub_osc_en", !mreg[`CSR_IDX_OSC][2], co.sub_osc_en)
   endtask

   // Measures the spacing of CPU clock enables once the new divider is in use.
   task automatic tick_gap(input int want);
      repeat (3) begin
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (co.cpu_tick !== 1'b1 && n < 40);
      end
      `CHK("tick gap", want, n)
   endtask

   task automatic pulse(input int which);
      @(posedge pclk);
      if (which == 0) do_stop <= 1'b1;
      else if (which == 1) do_pin_rst <= 1'b1;
      else bt_overflow <= 1'b1;
      @(posedge pclk);
      do_stop     <= 1'b0;
      do_pin_rst  <= 1'b0;
      bt_overflow <= 1'b0;
   endtask

   task automatic stop_wait();
      pulse(0);
      `WAITF(so.stop_mode === 1'b1)
   endtask

   initial begin
      req = '0;
      {presetn, ext_irq, wt_irq, wt_on_sub, bt_overflow, do_stop, do_pin_rst} = '0;
      num_errors = 0;
      check_count = 0;
      lfsr = 16'h002b;
      foreach (gaps[i]) mreg[i] = 0;
      mreg.delete();
      mreg[`CSR_IDX_OSC] = 0;
      mreg[`CSR_IDX_CLK] = 0;
      mreg[`CSR_IDX_BT] = 0;
      mreg[`CSR_IDX_KEY] = 0;
      mreg[`CSR_IDX_STAT] = 0;
      repeat (5) @(posedge pclk);
      `CHK("irq_disable", 1'b1, so.irq_disable)
      `CHK("watchdog_en", 1'b1, so.watchdog_en)
      `CHK("port_reset", 1'b1, so.port_reset_mode)
      presetn <= 1'b1;
      n = 0;
      while (so.pc_load !== 1'b1 && n < 500) begin
         @(posedge pclk);
         n++;
      end
      `CHK("stab wait", 1'b1, n >= STAB + 2 && n < 500)
      `CHK("pc_vector", 16'h0100, so.pc_vector)
      rd_all();
      `CHK("irq enabled", 1'b0, so.irq_disable)
      apb(1'b1, `CSR_IDX_OSC, 8'h01);
      chk_osc();
      repeat (16) @(posedge pclk);
      apb(1'b1, `CSR_IDX_OSC, 8'h09);
      chk_osc();
      apb(1'b1, `CSR_IDX_OSC, 8'h01);
      repeat (16) @(posedge pclk);
      apb(1'b1, `CSR_IDX_OSC, 8'h00);
      chk_osc();
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         apb(1'b1, `CSR_IDX_OSC, lfsr[7:0] & 8'h07);
         chk_osc();
      end
      apb(1'b1, `CSR_IDX_OSC, 8'h00);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `CSR_IDX_CLK, 8'(c << 3));
         tick_gap(gaps[c]);
      end
      apb(1'b1, `CSR_IDX_CLK, 8'h10);
      apb(1'b1, `CSR_IDX_KEY, 8'ha4);
      pulse(0);
      `WAITF(so.stop_ignored === 1'b1)
      `CHK("stop refused", 1'b0, so.stop_mode)
      apb(1'b1, `CSR_IDX_KEY, `CSR_STOP_KEY);
      stop_wait();
      `CHK("halt", 1'b1, so.cpu_halt)
      `CHK("main off", 1'b0, co.main_osc_en)
      ext_irq <= 1'b1;
      `WAITF(so.irq_service === 1'b1)
      ext_irq <= 1'b0;
      `CHK("resume", 1'b1, so.fetch_en)
      rd_all();
      tick_gap(2);
      wt_on_sub <= 1'b1;
      stop_wait();
      wt_irq <= 1'b1;
      `WAITF(so.irq_service === 1'b1)
      wt_irq <= 1'b0;
      apb(1'b1, `CSR_IDX_OSC, 8'h01);
      stop_wait();
      ext_irq <= 1'b1;
      wt_irq  <= 1'b1;
      repeat (40) @(posedge pclk);
      `CHK("sub stop held", 1'b1, so.stop_mode)
      ext_irq <= 1'b0;
      wt_irq  <= 1'b0;
      pulse(1);
      `WAITF(so.sys_reset === 1'b1)
      mreset();
      `WAITF(so.pc_load === 1'b1)
      rd_all();
      pulse(2);
      `WAITF(so.sys_reset === 1'b1)
      `WAITF(so.pc_load === 1'b1)
      apb(1'b1, `CSR_IDX_BT, 8'ha0);
      repeat (2) @(posedge pclk);
      `CHK("watchdog off", 1'b0, so.watchdog_en)
      pulse(2);
      repeat (6) @(posedge pclk);
      `CHK("no trip", 1'b0, so.sys_reset)
      apb(1'b0, 8'h10, 8'h00);
      apb(1'b1, `CSR_IDX_STAT, 8'hff);
      end_of_test();
   end
endmodule
